// ==== hw/resizer_output_writer.sv ====
`timescale 1ns/1ps
module resizer_output_writer
  import resizer_output_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic               hclk,      // Pipe clock, 250 MHz
  input  wire logic               hresetn,   // Async reset, low
  input  wire logic               hsel,      // Slave select
  input  wire logic [31:0]        haddr,     // Byte address
  input  wire logic [1:0]         htrans,    // Transfer type
  input  wire logic               hwrite,    // Write not read
  input  wire logic [2:0]         hsize,     // Word only
  input  wire logic [31:0]        hwdata,    // Write data
  input  wire logic               hready,    // Bus ready
  output logic      [31:0]        hrdata,    // Read data
  output logic                    hreadyout, // Always ready
  output logic                    hresp,     // Always OKAY
  input  wire logic               pix_valid, // Pixel offered
  output logic                    pix_ready, // Pixel taken
  input  wire logic [23:0]        pix_data,  // R,G,B or Y/C sample
  input  wire logic               pix_sof,   // First pixel of frame
  input  wire logic               pix_eol,   // Last pixel of line
  output logic                    mem_valid, // Write request
  input  wire logic               mem_ready, // Memory accepts
  output logic      [ADDR_W-1:0]  mem_addr,  // Byte address
  output logic      [31:0]        mem_data,  // Write word
  output logic                    mem_half   // 16-bit write
);

  generate
    if (FIFO_DEPTH < 4) begin : g_bad_depth
      $error("resizer_output_writer needs FIFO_DEPTH of 4 or more");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] pack_pixel(
    input logic rgb, input logic w16, input logic [7:0] alpha,
    input logic [23:0] px);
    if (rgb && !w16) pack_pixel = {alpha, px};
    else if (rgb)    pack_pixel = {16'h0000, px[23:19], px[15:10],
                                   px[7:3]};
    else             pack_pixel = {16'h0000, px[15:0]};
  endfunction

  function automatic logic [ADDR_W-1:0] align32(
    input logic [ADDR_W-1:0] a);
    align32 = (a + ALIGN_ADD) & ALIGN_MSK;
  endfunction

  function automatic logic [15:0] reg_next(
    input logic we, input logic [15:0] cur, input logic [15:0] wd,
    input logic [15:0] msk);
    reg_next = we ? (wd & msk) : cur;
  endfunction

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic [15:0] fmt_reg, alpha_reg, bhi_reg, blo_reg;
  logic [15:0] shi_reg, slo_reg, pitch_reg, en_reg, cap_reg;
  logic [15:0] fmt_next, alpha_next, bhi_next, blo_next;
  logic [15:0] shi_next, slo_next, pitch_next, en_next, cap_next;
  logic [7:0]  wr_addr_reg;
  logic        wr_pend_reg;
  logic [31:0] hrdata_reg;
  logic [LINE_W-1:0] line_num_reg;

  wire        bus_go  = hsel & hready & htrans[HTRANS_ACTIVE_BIT];
  wire        rd_go   = bus_go & ~hwrite;
  wire [15:0] wd      = hwdata[15:0];
  wire [7:0]  ra      = haddr[7:0];

  assign fmt_next   = reg_next(wr_pend_reg && wr_addr_reg == OFS_FORMAT,
                               fmt_reg, wd, MASK_FORMAT);
  assign alpha_next = reg_next(wr_pend_reg && wr_addr_reg == OFS_ALPHA,
                               alpha_reg, wd, MASK_ALPHA);
  assign bhi_next   = reg_next(wr_pend_reg && wr_addr_reg == OFS_BASE_HI,
                               bhi_reg, wd, MASK_HIGH);
  assign blo_next   = reg_next(wr_pend_reg && wr_addr_reg == OFS_BASE_LO,
                               blo_reg, wd, MASK_FULL);
  assign shi_next   = reg_next(wr_pend_reg && wr_addr_reg == OFS_START_HI,
                               shi_reg, wd, MASK_HIGH);
  assign slo_next   = reg_next(wr_pend_reg && wr_addr_reg == OFS_START_LO,
                               slo_reg, wd, MASK_FULL);
  assign pitch_next = reg_next(wr_pend_reg && wr_addr_reg == OFS_PITCH,
                               pitch_reg, wd, MASK_FULL);
  assign en_next    = reg_next(wr_pend_reg && wr_addr_reg == OFS_RGB_EN,
                               en_reg, wd, MASK_EN);
  assign cap_next   = reg_next(wr_pend_reg && wr_addr_reg == OFS_CAPACITY,
                               cap_reg, wd, MASK_CAP);

  // Reads see a write finishing in the same cycle
  wire [15:0] rd_word =
    (ra == OFS_FORMAT)   ? fmt_next   :
    (ra == OFS_ALPHA)    ? alpha_next :
    (ra == OFS_BASE_HI)  ? bhi_next   :
    (ra == OFS_BASE_LO)  ? blo_next   :
    (ra == OFS_START_HI) ? shi_next   :
    (ra == OFS_START_LO) ? slo_next   :
    (ra == OFS_PITCH)    ? pitch_next :
    (ra == OFS_RGB_EN)   ? en_next    :
    (ra == OFS_CAPACITY) ? cap_next   :
    (ra == OFS_LINE_POS) ? {3'h0, line_num_reg} : 16'h0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h00000000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= bus_go & hwrite;
      wr_addr_reg <= ra;
      if (rd_go) begin
        hrdata_reg <= {16'h0000, rd_word};
      end
    end
  end
  assign hrdata = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fmt_reg   <= RST_ZERO;
      alpha_reg <= RST_ZERO;
      bhi_reg   <= RST_ZERO;
      blo_reg   <= RST_ZERO;
      shi_reg   <= RST_ZERO;
      slo_reg   <= RST_ZERO;
      pitch_reg <= RST_ZERO;
      en_reg    <= RST_ZERO;
      cap_reg   <= RST_CAP;
    end else begin
      fmt_reg   <= fmt_next;
      alpha_reg <= alpha_next;
      bhi_reg   <= bhi_next;
      blo_reg   <= blo_next;
      shi_reg   <= shi_next;
      slo_reg   <= slo_next;
      pitch_reg <= pitch_next;
      en_reg    <= en_next;
      cap_reg   <= cap_next;
    end
  end

  // ---------------------------------------------------------------
  // Mode and address decode
  // ---------------------------------------------------------------
  // RGB enable picks format
  wire rgb     = en_reg[EN_BIT];
  wire w16     = fmt_reg[FMT_WIDTH_BIT];
  wire lead_m  = fmt_reg[FMT_LEAD_BIT];
  wire trail_m = fmt_reg[FMT_TRAIL_BIT];
  wire half_px = ~rgb | w16;
  wire [ADDR_W-1:0] bpp = half_px ? BPP_HALF : BPP_ARGB;

  wire [ADDR_W-1:0] base_full  = {bhi_reg[HIGH_W-1:0], blo_reg};
  wire [ADDR_W-1:0] start_full = {shi_reg[HIGH_W-1:0], slo_reg};
  wire [ADDR_W-1:0] pitch_eff  = ADDR_W'(pitch_reg & MASK_PITCH);

  // ---------------------------------------------------------------
  // Line tracking and pixel entry
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] line_addr_reg;
  logic [ADDR_W-1:0] col_reg;
  logic [1:0]        lidx_reg;
  logic              pix_ready_reg;

  wire acc = pix_valid & pix_ready_reg;
  wire [ADDR_W-1:0] line_cur = pix_sof ? start_full : line_addr_reg;
  wire [ADDR_W-1:0] col_cur  = pix_sof ? '0 : col_reg;
  wire [LINE_W-1:0] lnum_cur = pix_sof ? '0 : line_num_reg;
  wire [1:0]        lidx_cur = pix_sof ? 2'h0 : lidx_reg;
  // first two pixels marked for drop
  wire lead_drop = lead_m & (lidx_cur < LEAD_COUNT);
  wire [31:0] pk_data = pack_pixel(rgb, w16, alpha_reg[7:0], pix_data);
  wire [ADDR_W-1:0] pk_addr = line_cur + col_cur;
  wire [ADDR_W-1:0] col_adv = col_cur + (lead_drop ? '0 : bpp);
  wire [ENT_W-1:0]  new_ent = {lead_drop, half_px, pk_addr, pk_data};
  // wrap once line count reaches capacity
  wire wrap = (lnum_cur == cap_reg[LINE_W-1:0]);
  // next line from pitch, or packed end in RGB
  wire [ADDR_W-1:0] next_line =
    wrap ? base_full :
    rgb  ? align32(line_cur + col_adv) : line_cur + pitch_eff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_addr_reg <= '0;
      col_reg       <= '0;
      line_num_reg  <= '0;
      lidx_reg      <= 2'h0;
    end else if (acc) begin
      line_addr_reg <= pix_eol ? next_line : line_cur;
      col_reg       <= pix_eol ? '0 : col_adv;
      line_num_reg  <= pix_eol ? (wrap ? '0 : lnum_cur + 1'b1) : lnum_cur;
      lidx_reg      <= (pix_eol) ? 2'h0 :
                       (lidx_cur == LEAD_COUNT) ? lidx_cur :
                       lidx_cur + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Two-pixel hold so the line tail can be dropped
  // ---------------------------------------------------------------
  flow_state_type    state_reg, state_next;
  logic [ENT_W-1:0]  h0_reg, h1_reg, h0_next, h1_next;
  logic [1:0]        cnt_reg, cnt_next;
  logic              fifo_in_ready;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;

  wire h0_lead   = h0_reg[ENT_W-1];
  wire shift_out = (state_reg == ST_ACCEPT) ? (acc && cnt_reg == 2'h2) :
                   (cnt_reg != 2'h0) && (h0_lead || fifo_in_ready);
  wire push      = shift_out & ~h0_lead;

  always_comb begin
    state_next = state_reg;
    h0_next    = h0_reg;
    h1_next    = h1_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_ACCEPT: begin
        if (acc) begin
          if (cnt_reg == 2'h2) begin
            h0_next = h1_reg;
            h1_next = new_ent;
          end else if (cnt_reg == 2'h1) begin
            h1_next  = new_ent;
            cnt_next = 2'h2;
          end else begin
            h0_next  = new_ent;
            cnt_next = 2'h1;
          end
          // tail pair discarded at line end
          if (pix_eol && trail_m) begin
            cnt_next = 2'h0;
          end else if (pix_eol) begin
            state_next = ST_FLUSH;
          end
        end
      end
      ST_FLUSH: begin
        if (shift_out) begin
          h0_next  = h1_reg;
          cnt_next = cnt_reg - 2'h1;
          if (cnt_reg == 2'h1) begin
            state_next = ST_ACCEPT;
          end
        end
      end
      default: begin
        state_next = ST_ACCEPT;
        cnt_next   = 2'h0;
      end
    endcase
  end

  // Ready only when a forced push can never find the FIFO full
  wire ready_next = (state_next == ST_ACCEPT) &&
    (cnt_next != 2'h2 ||
     fifo_level <= ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - 2));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= ST_ACCEPT;
      h0_reg        <= '0;
      h1_reg        <= '0;
      cnt_reg       <= 2'h0;
      pix_ready_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      h0_reg        <= h0_next;
      h1_reg        <= h1_next;
      cnt_reg       <= cnt_next;
      pix_ready_reg <= ready_next;
    end
  end
  assign pix_ready = pix_ready_reg;

  // ---------------------------------------------------------------
  // FIFO and memory write port
  // ---------------------------------------------------------------
  logic              fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic              mem_valid_reg, mem_half_reg;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic [31:0]       mem_data_reg;

  wire load = fifo_out_valid & (~mem_valid_reg | mem_ready);

  pixel_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (h0_reg[WORD_W-1:0]),
    .out_valid (fifo_out_valid),
    .out_ready (load),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_valid_reg <= 1'b0;
      mem_half_reg  <= 1'b0;
      mem_addr_reg  <= '0;
      mem_data_reg  <= 32'h00000000;
    end else if (load) begin
      mem_valid_reg <= 1'b1;
      {mem_half_reg, mem_addr_reg, mem_data_reg} <= fifo_out_data;
    end else if (mem_ready) begin
      mem_valid_reg <= 1'b0;
    end
  end
  assign mem_valid = mem_valid_reg;
  assign mem_half  = mem_half_reg;
  assign mem_addr  = mem_addr_reg;
  assign mem_data  = mem_data_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_trail_drop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && pix_eol && trail_m && state_reg == ST_ACCEPT)
      |=> (cnt_reg == 2'h0 && state_reg == ST_ACCEPT))
    else $error("tail pixels kept despite trailing mask");

  a_lead_never: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && lead_m && lidx_cur != LEAD_COUNT)
      |-> (new_ent[ENT_W-1] && col_adv == col_cur))
    else $error("leading pixel not marked for drop");

  a_argb_word: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (push && rgb && !w16 && $stable(fmt_reg) && $stable(en_reg))
      |-> !h0_reg[WORD_W-1])
    else $error("argb pixel written as halfword");

  a_rgb565_pack: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && rgb && w16) |-> (pk_data[15:11] == pix_data[23:19] &&
      pk_data[10:5] == pix_data[15:10] && pk_data[4:0] == pix_data[7:3] &&
      pk_data[31:16] == 16'h0000))
    else $error("565 packing wrong");

  a_alpha_byte: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && rgb && !w16) |=> (lead_m || cnt_reg == 2'h0 ||
      (cnt_reg == 2'h1 ? h0_reg[31:24] : h1_reg[31:24])
        == $past(alpha_reg[7:0]))
      || $past(pix_eol))
    else $error("alpha byte not taken from register");

  a_start_addr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && pix_sof && $stable(shi_reg) && $stable(slo_reg))
      |-> pk_addr == {shi_reg[HIGH_W-1:0], slo_reg})
    else $error("first pixel not at start address");

  a_pitch_step: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && pix_eol && !rgb && !wrap)
      |=> line_addr_reg == $past(line_cur) +
          ADDR_W'($past(pitch_reg) & MASK_PITCH))
    else $error("line address not start plus pitch");

  a_pitch_align: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && pix_eol && !rgb && !wrap)
      |=> line_addr_reg[ALIGN_BITS-1:0] ==
          $past(line_cur[ALIGN_BITS-1:0]))
    else $error("pitch low bits not forced to zero");

  a_rgb_nopitch: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && pix_eol && rgb && !wrap)
      |=> line_addr_reg[ALIGN_BITS-1:0] == '0)
    else $error("rgb line address not 32-byte packed");

  a_normal_half: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && !rgb) |-> new_ent[ENT_W-2])
    else $error("normal output not halfword");

  a_line_wrap: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && pix_eol && wrap)
      |=> (line_num_reg == '0 && line_addr_reg == $past(base_full)))
    else $error("line addressing did not wrap to base");

endmodule

// ==== hw/resizer_output_pkg.sv ====
package resizer_output_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int REG_W   = 16;
  localparam int ADDR_W  = 28;
  localparam int LINE_W  = 13;
  localparam int HIGH_W  = 12;
  localparam int ENT_W   = 62;
  localparam int WORD_W  = 61;

  // ---------------------------------------------------------------
  // Register byte offsets (decoded on haddr[7:0])
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_FORMAT    = 8'h00;
  localparam logic [7:0] OFS_ALPHA     = 8'h04;
  localparam logic [7:0] OFS_BASE_HI   = 8'h08;
  localparam logic [7:0] OFS_BASE_LO   = 8'h0C;
  localparam logic [7:0] OFS_START_HI  = 8'h10;
  localparam logic [7:0] OFS_START_LO  = 8'h14;
  localparam logic [7:0] OFS_PITCH     = 8'h18;
  localparam logic [7:0] OFS_RGB_EN    = 8'h1C;
  localparam logic [7:0] OFS_CAPACITY  = 8'h20;
  localparam logic [7:0] OFS_LINE_POS  = 8'h24;

  // ---------------------------------------------------------------
  // Field positions, write masks and reset values
  // ---------------------------------------------------------------
  localparam int FMT_WIDTH_BIT = 0;
  localparam int FMT_LEAD_BIT  = 1;
  localparam int FMT_TRAIL_BIT = 2;
  localparam int EN_BIT        = 0;
  localparam int ALIGN_BITS    = 5;

  localparam logic [15:0] MASK_FORMAT = 16'h0007;
  localparam logic [15:0] MASK_ALPHA  = 16'h00FF;
  localparam logic [15:0] MASK_HIGH   = 16'h0FFF;
  localparam logic [15:0] MASK_FULL   = 16'hFFFF;
  localparam logic [15:0] MASK_EN     = 16'h0001;
  localparam logic [15:0] MASK_CAP    = 16'h1FFF;
  localparam logic [15:0] MASK_PITCH  = 16'hFFE0;
  localparam logic [15:0] RST_ZERO    = 16'h0000;
  localparam logic [15:0] RST_CAP     = 16'h1FFF;

  localparam logic [ADDR_W-1:0] BPP_ARGB  = 28'h0000004;
  localparam logic [ADDR_W-1:0] BPP_HALF  = 28'h0000002;
  localparam logic [ADDR_W-1:0] ALIGN_ADD = 28'h000001F;
  localparam logic [ADDR_W-1:0] ALIGN_MSK = 28'hFFFFFE0;

  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [1:0] LEAD_COUNT = 2'h2;

  typedef enum logic [1:0] {
    ST_ACCEPT = 2'b00,
    ST_FLUSH  = 2'b01
  } flow_state_type;

endpackage

// ==== hw/pixel_fifo.sv ====
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int WIDTH = 61,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk,       // Clock
  input  wire logic                       rst_n,     // Async reset, low
  input  wire logic                       in_valid,  // Write request
  output logic                            in_ready,  // Not full
  input  wire logic [WIDTH-1:0]           in_data,   // Write word
  output logic                            out_valid, // Not empty
  input  wire logic                       out_ready, // Read accept
  output logic [WIDTH-1:0]                out_data,  // Head word
  output logic [$clog2(DEPTH):0]          level      // Words stored
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("pixel_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      cnt_reg;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rptr_reg];
  assign level     = cnt_reg;
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      wptr_reg <= wptr_reg + AW'(do_wr);
      rptr_reg <= rptr_reg + AW'(do_rd);
      cnt_reg  <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

endmodule

// ==== dv/mem_sink_model.sv ====
`timescale 1ns/1ps
module mem_sink_model (
  input  wire logic       hclk,      // Clock
  input  wire logic       hresetn,   // Async reset, low
  input  wire logic [1:0] mode,      // 0 fast, 1 slow, 2 stopped
  input  wire logic       mem_valid, // Write request
  output logic            mem_ready  // Write accepted
);
  // ---------------------------------------------------------------
  // Ready pacing
  // ---------------------------------------------------------------
  logic [1:0] phase_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= 2'h0;
      mem_ready <= 1'b0;
    end else begin
      phase_reg <= phase_reg + {1'b0, mem_valid};
      mem_ready <= (mode == 2'h0) || (mode == 2'h1 && phase_reg == 2'h3);
    end
  end
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import resizer_output_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic pix_valid = 0, pix_sof = 0, pix_eol = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0] htrans = 0, mode = 0;
  logic [2:0] hsize = 3'h2;
  logic [23:0] pix_data = 0;
  wire [31:0] hrdata, mem_data;
  wire hreadyout, hresp, pix_ready, mem_valid, mem_ready, mem_half;
  wire [ADDR_W-1:0] mem_addr;
  int n_mismatch = 0, compares = 0, k = 0;
  logic [60:0] exp_q[$];
  always #2 hclk = ~hclk;
  resizer_output_writer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_data(pix_data), .pix_sof(pix_sof),
    .pix_eol(pix_eol), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .mem_addr(mem_addr), .mem_data(mem_data), .mem_half(mem_half));
  mem_sink_model mem (.hclk(hclk), .hresetn(hresetn), .mode(mode),
    .mem_valid(mem_valid), .mem_ready(mem_ready));
  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task end_sim;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  always @(negedge hclk) begin
    if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
      if (exp_q.size() == 0) check(64'h1, 64'h0);
      else check({mem_addr, mem_data, mem_half}, exp_q.pop_front());
    end
  end
  // ---------------------------------------------------------------
  // Bus and pixel drivers
  // ---------------------------------------------------------------
  task xfer(input logic w, input logic [7:0] a, input logic [15:0] wd,
            output logic [31:0] rd);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {16'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check({hreadyout, hresp}, 64'h2);
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task cfg(input logic [15:0] v [9]);
    for (int j = 0; j < 9; j++) wr(8'(j * 4), v[j]);
  endtask
  task line(input int n, input logic sof, input logic [27:0] la,
            input logic [2:0] fmt, input logic rgb, input logic [7:0] al,
            output logic [27:0] fin);
    logic [23:0] p;
    logic [27:0] col;
    col = 0;
    for (int i = 0; i < n; i++) begin
      p = 24'hC86420 ^ {3{8'(k)}};
      k++;
      if (!(fmt[1] && i < 2) && !(fmt[2] && i >= n - 2)) begin
        if (!rgb) exp_q.push_back({la + col, 16'h0, p[15:0], 1'b1});
        else if (!fmt[0]) exp_q.push_back({la + col, al, p, 1'b0});
        else exp_q.push_back({la + col, 16'h0, p[23:19], p[15:10],
                              p[7:3], 1'b1});
        col += (rgb && !fmt[0]) ? 28'h4 : 28'h2;
      end
      pix_valid <= 1'b1;
      pix_data <= p;
      pix_sof <= sof && i == 0;
      pix_eol <= i == n - 1;
      do @(posedge hclk); while (pix_ready !== 1'b1);
    end
    pix_valid <= 1'b0;
    fin = la + col;
    @(posedge hclk);
  endtask
  task drain;
    for (int t = 0; t < 3000 && exp_q.size() != 0; t++) @(posedge hclk);
    check(exp_q.size(), 0);
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic [27:0] a;
    logic [15:0] wm [11];
    wm = '{MASK_FORMAT, MASK_ALPHA, MASK_HIGH, MASK_FULL, MASK_HIGH,
           MASK_FULL, MASK_FULL, MASK_EN, MASK_CAP, RST_ZERO, RST_ZERO};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    for (int j = 0; j < 11; j++) begin
      xfer(1'b0, 8'(j * 4), 16'h0, rd);
      check(rd, (j == 8) ? {16'h0, RST_CAP} : 32'h0);
    end
    for (int j = 0; j < 11; j++) begin
      wr(8'(j * 4), 16'hFFFF);
      xfer(1'b0, 8'(j * 4), 16'h0, rd);
      check(rd, {16'h0, wm[j]});
    end
    cfg('{16'h0, 16'h0, 16'h00AB, 16'h1000, 16'h0012, 16'h3400, 16'h0047,
          16'h0, 16'h0001});
    line(3, 1'b1, 28'h0123400, 3'h0, 1'b0, 8'h0, a);
    line(3, 1'b0, 28'h0123440, 3'h0, 1'b0, 8'h0, a);
    line(3, 1'b0, 28'h0AB1000, 3'h0, 1'b0, 8'h0, a);
    drain;
    cfg('{16'h0, 16'h005A, 16'h0, 16'h0, 16'h0012, 16'h3400, 16'h0100,
          16'h0001, 16'h1FFF});
    mode <= 2'h1;
    line(5, 1'b1, 28'h0123400, 3'h0, 1'b1, 8'h5A, a);
    line(4, 1'b0, 28'h0123420, 3'h0, 1'b1, 8'h5A, a);
    drain;
    for (int f = 1; f < 8; f += 2) begin
      wr(OFS_FORMAT, 16'(f));
      line(6, 1'b1, 28'h0123400, 3'(f), 1'b1, 8'h5A, a);
      drain;
    end
    wr(OFS_FORMAT, 16'h0);
    mode <= 2'h2;
    fork
      line(24, 1'b1, 28'h0123400, 3'h0, 1'b1, 8'h5A, a);
      begin
        repeat (80) @(negedge hclk);
        check(pix_ready, 0);
        @(posedge hclk);
        mode <= 2'h0;
      end
    join
    drain;
    end_sim;
  end
  initial begin
    repeat (30000) @(posedge hclk);
    n_mismatch++;
    end_sim;
  end
endmodule
